// >>> pkg/hcsc_pkg.sv
// Constants, register map and carrier types for the high-speed channel
// sync and coding control block. Assumes a single pclk domain.
package hcsc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  REG_CTRL_IDX     = 8'h1d;
    localparam logic [7:0]  REG_IADDR_IDX    = 8'h1e;
    localparam logic [7:0]  REG_IDATA_IDX    = 8'h1f;
    localparam logic [7:0]  REG_IRQ_STAT_IDX = 8'h20;
    localparam logic [7:0]  REG_IRQ_MASK_IDX = 8'h21;
    localparam logic [7:0]  REG_STATUS_IDX   = 8'h22;
    localparam logic [7:0]  REG_JOG_IDX      = 8'h23;

    // Control register fields and reset value
    localparam logic [15:0] CTRL_RESET       = 16'h0880;
    localparam int          CTRL_DEPTH_LSB   = 12;
    localparam int          CTRL_RXMK_BIT    = 11;
    localparam int          CTRL_TXMK_BIT    = 7;
    localparam int          CTRL_FORCE_BIT   = 5;
    localparam int          CTRL_SLIP_BIT    = 4;
    localparam int          CTRL_ENC_BIT     = 3;
    localparam int          CTRL_DEC_BIT     = 2;
    localparam int          CTRL_POL_LSB     = 0;
    localparam logic [15:0] IADDR_RESET      = 16'h0000;

    // Extended space: marker characters
    localparam logic [15:0] EXT_BASE         = 16'h8000;
    localparam int          EXT_NUM          = 4;
    localparam int          EXT_TX_SEARCH    = 0;
    localparam int          EXT_TX_REPLACE   = 1;
    localparam int          EXT_RX_SEARCH    = 2;
    localparam int          EXT_RX_REPLACE   = 3;
    localparam logic [9:0]  EXT_RESET [EXT_NUM] = '{10'h2bc, 10'h27c, 10'h27c, 10'h2bc};

    // Alignment and sync policy constants
    localparam logic [3:0]  ALIGN_FORCED     = 4'h9;
    localparam logic [3:0]  ALIGN_LAST       = 4'h9;
    localparam logic [1:0]  ACQ_COMMAS       = 2'h3;
    localparam logic [1:0]  GOOD_RUN         = 2'h3;
    localparam logic [2:0]  ERR_LEVEL_LOSS   = 3'h4;
    localparam logic [1:0]  POL_ETHERNET     = 2'h0;

    // Interrupt bits
    localparam int          IRQ_W            = 3;
    localparam int          IRQ_LOST         = 0;
    localparam int          IRQ_GAINED       = 1;
    localparam int          IRQ_CODE_ERR     = 2;

    typedef struct packed {
        logic       valid;
        logic       code_err;
        logic       disp_err;
        logic       comma;
        logic [3:0] comma_pos;
        logic [9:0] data;
    } hcsc_rx_t;

    typedef struct packed {
        logic       valid;
        logic [9:0] data;
    } hcsc_char_t;

    typedef struct packed {
        logic       enc_skip;
        logic       dec_skip;
        logic       slip_en;
        logic [2:0] fifo_depth;
    } hcsc_ctrl_t;

    typedef enum logic [1:0] {
        SYNC_LOS,
        SYNC_ACQ,
        SYNC_LOCKED
    } hcsc_sync_t;

endpackage

// >>> hw/hcsc_top.sv
// Sync policy, byte alignment select, coding bypass and marker swap control
// for one high-speed channel. Assumes the serdes datapath shares pclk and
// presents one decoded character per valid cycle.
`timescale 1ns/10ps

// Summary of operation
// RL1 - Default policy uses Ethernet hysteresis before loss
// RL2 - Policy 01: one error drops sync
// RL3 - Policy 10: two consecutive errors drop sync
// RL4 - Policy 11: three consecutive errors drop sync
// RL5 - Force bit without slip fixes alignment at nine
// RL6 - Force and slip bits clear use sync machine alignment
// RL7 - Slip enable turns manual jog on
// RL8 - Encoder skip bypasses transmit 8b/10b encoder
// RL9 - Decoder skip bypasses receive 8b/10b decoder
// RL10 - Receive marker swap replaces search character
// RL11 - Transmit marker swap replaces search character
// RL12 - One depth field sets both receive FIFOs
// RL13 - Software writes pointer then uses data register
// RL14 - Data register reaches pointed extended register
// RL15 - Receive markers reset to 27c and 2bc
// RL16 - Clean character clears consecutive error count
module hcsc_top (
    // APB slave
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Interrupt
    output logic                    irq,
    // Receive character stream
    input  wire hcsc_pkg::hcsc_rx_t   rx_in,
    output hcsc_pkg::hcsc_char_t      rx_out,
    // Transmit character stream
    input  wire hcsc_pkg::hcsc_char_t tx_in,
    output hcsc_pkg::hcsc_char_t      tx_out,
    // Datapath control
    output hcsc_pkg::hcsc_ctrl_t      ctrl,
    output logic      [3:0]         align_pos,
    output logic                    synced
);
    import hcsc_pkg::*;

    logic [15:0]        ctrl_q;
    logic [15:0]        iaddr_q;
    logic [9:0]         ext_q [EXT_NUM];
    logic [IRQ_W-1:0]   irq_stat_q;
    logic [IRQ_W-1:0]   irq_mask_q;
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    logic               irq_q;
    hcsc_sync_t         state_q;
    logic [1:0]         acq_cnt_q;
    logic [2:0]         err_cnt_q;
    logic [1:0]         good_cnt_q;
    logic [3:0]         found_pos_q;
    logic [3:0]         jog_pos_q;
    logic [3:0]         align_q;
    logic               synced_q;
    hcsc_char_t         rx_out_q;
    hcsc_char_t         tx_out_q;
    logic               ev_lost;
    logic               ev_gained;
    logic               ev_bad;
    logic [31:0]        rd_d;
    logic               hit_d;

    // Extended space decode, used by read and write
    function automatic logic ext_hit(input logic [15:0] a);
        return (a >= EXT_BASE) && (a < EXT_BASE + 16'(EXT_NUM));
    endfunction

    function automatic logic [1:0] ext_idx(input logic [15:0] a);
        return a[1:0];
    endfunction

    // Word aligned, register index in byte address bits 9:2
    logic       acc;
    logic       wr;
    logic [7:0] idx;
    assign acc = psel && penable && pready_q;
    assign wr  = acc && pwrite;
    assign idx = (paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0) ? paddr[9:2] : 8'hff;

    wire [1:0] policy   = ctrl_q[CTRL_POL_LSB +: 2];
    wire       bad_char = rx_in.valid && (rx_in.code_err || rx_in.disp_err);

    // Read mux
    always_comb begin
        rd_d  = 32'h0;
        hit_d = 1'b1;
        unique case (idx)
            REG_CTRL_IDX:     rd_d = {16'h0, ctrl_q};
            REG_IADDR_IDX:    rd_d = {16'h0, iaddr_q};
            REG_IDATA_IDX:    rd_d = ext_hit(iaddr_q) ? {22'h0, ext_q[ext_idx(iaddr_q)]} : 32'h0; // RL14
            REG_IRQ_STAT_IDX: rd_d = {{(32-IRQ_W){1'b0}}, irq_stat_q};
            REG_IRQ_MASK_IDX: rd_d = {{(32-IRQ_W){1'b0}}, irq_mask_q};
            REG_STATUS_IDX:   rd_d = {21'h0, synced_q, state_q, align_q, 1'b0, err_cnt_q};
            REG_JOG_IDX:      rd_d = {28'h0, jog_pos_q};
            default:          hit_d = 1'b0;
        endcase
    end

    // No wait state: ready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= psel && !penable && !pready_q;
            pslverr_q <= psel && !penable && !hit_d;
            if (psel && !penable && !pwrite) begin
                prdata_q <= rd_d;
            end
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr && idx == REG_CTRL_IDX) begin
            ctrl_q <= pwdata[15:0];
        end
    end

    // Indirect address pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iaddr_q <= IADDR_RESET;
        end else if (wr && idx == REG_IADDR_IDX) begin
            iaddr_q <= pwdata[15:0]; // RL13
        end
    end

    // Extended marker characters; writes outside the mapped range are dropped
    for (genvar g = 0; g < EXT_NUM; g++) begin : g_ext
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ext_q[g] <= EXT_RESET[g]; // RL15
            end else if (wr && idx == REG_IDATA_IDX && ext_hit(iaddr_q)
                         && ext_idx(iaddr_q) == 2'(g)) begin
                ext_q[g] <= pwdata[9:0]; // RL14
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= '0;
        end else if (wr && idx == REG_IRQ_MASK_IDX) begin
            irq_mask_q <= pwdata[IRQ_W-1:0];
        end
    end

    // Sticky status; a new event beats a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((wr && idx == REG_IRQ_STAT_IDX) ?
                           pwdata[IRQ_W-1:0] : '0)) | {ev_bad, ev_gained, ev_lost};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Sync machine events
    always_comb begin
        ev_bad    = bad_char;
        ev_gained = 1'b0;
        ev_lost   = 1'b0;
        if (state_q == SYNC_ACQ && rx_in.valid && !bad_char && rx_in.comma
            && acq_cnt_q == ACQ_COMMAS - 2'h1) begin
            ev_gained = 1'b1;
        end
        if (state_q == SYNC_LOCKED && bad_char) begin
            if (policy == POL_ETHERNET) begin
                ev_lost = (err_cnt_q == ERR_LEVEL_LOSS - 3'h1); // RL1
            end else begin
                ev_lost = (err_cnt_q == {1'b0, policy} - 3'h1); // RL2 RL3 RL4
            end
        end
    end

    // Acquisition needs three clean commas with no bad character between; position comes from the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= SYNC_LOS;
            acq_cnt_q   <= 2'h0;
            found_pos_q <= 4'h0;
        end else if (rx_in.valid) begin
            unique case (state_q)
                SYNC_LOS: begin
                    if (rx_in.comma && !bad_char) begin
                        state_q     <= SYNC_ACQ;
                        acq_cnt_q   <= 2'h1;
                        found_pos_q <= rx_in.comma_pos;
                    end
                end
                SYNC_ACQ: begin
                    if (bad_char) begin
                        state_q <= SYNC_LOS;
                    end else if (ev_gained) begin
                        state_q <= SYNC_LOCKED;
                    end else if (rx_in.comma) begin
                        acq_cnt_q <= acq_cnt_q + 2'h1;
                    end
                end
                SYNC_LOCKED: begin
                    if (ev_lost) begin
                        state_q <= SYNC_LOS;
                    end
                end
            endcase
        end
    end

    // Error level under hysteresis, run length under consecutive policies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_cnt_q  <= 3'h0;
            good_cnt_q <= 2'h0;
        end else if (state_q != SYNC_LOCKED || ev_lost) begin
            err_cnt_q  <= 3'h0;
            good_cnt_q <= 2'h0;
        end else if (rx_in.valid) begin
            if (bad_char) begin
                err_cnt_q  <= err_cnt_q + 3'h1;
                good_cnt_q <= 2'h0;
            end else if (policy != POL_ETHERNET) begin
                err_cnt_q <= 3'h0; // RL16
            end else if (err_cnt_q != 3'h0) begin
                // Four clean characters in a row lower the level by one
                good_cnt_q <= good_cnt_q + 2'h1; // RL1
                if (good_cnt_q == GOOD_RUN) begin
                    err_cnt_q <= err_cnt_q - 3'h1;
                end
            end
        end
    end

    // Manual jog: each write to the jog register while slip is enabled steps one bit position
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jog_pos_q <= 4'h0;
        end else if (wr && idx == REG_JOG_IDX && ctrl_q[CTRL_SLIP_BIT]) begin
            jog_pos_q <= (jog_pos_q == ALIGN_LAST) ? 4'h0 : jog_pos_q + 4'h1; // RL7
        end
    end

    // Alignment select; slip enable takes precedence over forcing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            align_q  <= 4'h0;
            synced_q <= 1'b0;
        end else begin
            synced_q <= (state_q == SYNC_LOCKED);
            if (ctrl_q[CTRL_SLIP_BIT]) begin
                align_q <= jog_pos_q; // RL7
            end else if (ctrl_q[CTRL_FORCE_BIT]) begin
                align_q <= ALIGN_FORCED; // RL5
            end else begin
                align_q <= found_pos_q; // RL6
            end
        end
    end

    // Marker swap on both paths; one cycle of latency each way
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_out_q <= '0;
        end else begin
            rx_out_q.valid <= rx_in.valid;
            if (ctrl_q[CTRL_RXMK_BIT] && rx_in.data == ext_q[EXT_RX_SEARCH]) begin
                rx_out_q.data <= ext_q[EXT_RX_REPLACE]; // RL10
            end else begin
                rx_out_q.data <= rx_in.data;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_out_q <= '0;
        end else begin
            tx_out_q.valid <= tx_in.valid;
            if (ctrl_q[CTRL_TXMK_BIT] && tx_in.data == ext_q[EXT_TX_SEARCH]) begin
                tx_out_q.data <= ext_q[EXT_TX_REPLACE]; // RL11
            end else begin
                tx_out_q.data <= tx_in.data;
            end
        end
    end

    // Datapath controls come straight from the control register
    assign ctrl.enc_skip   = ctrl_q[CTRL_ENC_BIT]; // RL8
    assign ctrl.dec_skip   = ctrl_q[CTRL_DEC_BIT]; // RL9
    assign ctrl.slip_en    = ctrl_q[CTRL_SLIP_BIT];
    assign ctrl.fifo_depth = ctrl_q[CTRL_DEPTH_LSB +: 3]; // RL12

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign irq       = irq_q;
    assign rx_out    = rx_out_q;
    assign tx_out    = tx_out_q;
    assign align_pos = align_q;
    assign synced    = synced_q;

endmodule // hcsc_top

// >>> test/hcsc_checker.sv
// Port-level checks for the high-speed channel sync and coding control block.
// Assumes one pclk domain and the register map declared in hcsc_pkg.
`timescale 1ns/10ps
module hcsc_checker (
    // Clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // APB
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // Streams and controls
    input wire hcsc_pkg::hcsc_rx_t   rx_in,
    input wire hcsc_pkg::hcsc_char_t rx_out,
    input wire hcsc_pkg::hcsc_char_t tx_in,
    input wire hcsc_pkg::hcsc_char_t tx_out,
    input wire hcsc_pkg::hcsc_ctrl_t ctrl,
    input wire logic [3:0]           align_pos,
    input wire logic                 synced
);
    import hcsc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_ctrl;
    logic force_q;
    assign wr_ctrl = psel && penable && pready && pwrite && !pslverr
                     && paddr == 12'({REG_CTRL_IDX, 2'b00});
    // Shadow of the force bit, since the port list does not carry it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_q <= 1'b0;
        end else if (wr_ctrl) begin
            force_q <= pwdata[CTRL_FORCE_BIT];
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence forced_s;
        (force_q && !ctrl.slip_en) [*2];
    endsequence
    ready_after_setup_a: assert property (setup_s |=> pready)
        else $error("pready missing after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    error_reads_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    ctrl_follows_a: assert property (wr_ctrl |=> ctrl.fifo_depth == $past(pwdata[14:12])
        && ctrl.slip_en == $past(pwdata[4]) && ctrl.enc_skip == $past(pwdata[3])
        && ctrl.dec_skip == $past(pwdata[2])) else $error("control outputs wrong after write");
    rx_stream_a: assert property (rx_out.valid == $past(rx_in.valid))
        else $error("receive character lost or extra");
    tx_stream_a: assert property (tx_out.valid == $past(tx_in.valid))
        else $error("transmit character lost or extra");
    align_forced_a: assert property (forced_s |-> align_pos == ALIGN_FORCED)
        else $error("forced alignment not nine");
    loss_cause_a: assert property ($fell(synced)
        |-> $past(rx_in.valid && (rx_in.code_err || rx_in.disp_err), 2))
        else $error("sync lost without a bad character");
    gain_cause_a: assert property ($rose(synced) |-> $past(rx_in.valid && rx_in.comma, 2))
        else $error("sync gained without a comma");
endmodule // hcsc_checker

bind hcsc_top hcsc_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_in, .rx_out, .tx_in, .tx_out, .ctrl, .align_pos, .synced);

// >>> test/hcsc_link_model.sv
// Remote transceiver: delivers decoded characters to the receive stream.
// Assumes characters are sampled on the rising edge of pclk.
`timescale 1ns/10ps
module hcsc_link_model (
    // Clock
    input wire logic          pclk,
    // Receive characters
    output hcsc_pkg::hcsc_rx_t rx_in
);
    import hcsc_pkg::*;
    initial rx_in = '0;
    // Idle cycles show inverted data so a stale character never looks valid
    task automatic send(input logic c, input logic ce, input logic de, input logic [3:0] pos,
                        input logic [9:0] d);
        @(posedge pclk);
        rx_in <= '{1'b1, ce, de, c, pos, d};
        @(posedge pclk);
        rx_in.valid <= 1'b0;
        rx_in.data <= ~d;
    endtask
endmodule // hcsc_link_model

// >>> test/hs_channel_sync_coding_control_test.sv
// Self-checking bench for the channel control block over APB and the streams.
// Assumes the link model drives rx_in and the bench drives tx_in.
`timescale 1ns/10ps
module hs_channel_sync_coding_control_test;
    import hcsc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, synced, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  align_pos;
    hcsc_rx_t    rx_in;
    hcsc_char_t  rx_out, tx_in, tx_out;
    hcsc_ctrl_t  ctrl;
    int          n_fail = 0;
    int          n_tests = 0;
    hcsc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .rx_in, .rx_out, .tx_in, .tx_out, .ctrl, .align_pos, .synced);
    hcsc_link_model link_u (.pclk, .rx_in);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic end_sim;
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Ready and read data are taken at the rising edge that completes the access
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask
    task automatic rx_chk(input logic [9:0] d, input logic [9:0] exp);
        link_u.send(1'b0, 1'b0, 1'b0, 4'h0, d);
        @(negedge pclk);
        chk("rx_out", {22'h0, exp}, {22'h0, rx_out.data});
    endtask
    task automatic tx_chk(input logic [9:0] d, input logic [9:0] exp);
        @(posedge pclk);
        tx_in <= '{1'b1, d};
        @(posedge pclk);
        tx_in <= '{1'b0, ~d};
        @(negedge pclk);
        chk("tx_out", {22'h0, exp}, {22'h0, tx_out.data});
    endtask
    task automatic lock;
        link_u.send(1'b1, 1'b0, 1'b0, 4'h3, 10'h0fa);
        link_u.send(1'b1, 1'b0, 1'b0, 4'h6, 10'h0fa);
        link_u.send(1'b1, 1'b0, 1'b0, 4'h6, 10'h0fa);
        repeat (3) @(negedge pclk);
    endtask
    // Alternates code and disparity errors so both kinds are counted
    task automatic bad(input int n);
        for (int i = 0; i < n; i++) link_u.send(1'b0, i[0] == 0, i[0] == 1, 4'h0, 10'h0aa);
        repeat (3) @(negedge pclk);
    endtask
    task automatic t_regs;
        rdc("ctrl", 12'h074, 32'h0880);
        chk("ctrl_port", 32'h0, {26'h0, ctrl});
        rdc("pointer", 12'h078, 32'h0);
        apb(1'b1, 12'h078, 32'h8002);
        rdc("rx_search", 12'h07c, 32'h27c);
        apb(1'b1, 12'h078, 32'h8003);
        rdc("rx_replace", 12'h07c, 32'h2bc);
        rdc("bad_addr", 12'h3fc, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
    endtask
    task automatic t_ctrl;
        logic [15:0] v [2] = '{16'h789c, 16'h2880};
        logic [5:0]  e [2] = '{6'h3f, 6'h02};
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, 12'h074, {16'h0, v[i]});
            @(negedge pclk);
            chk("ctrl_port", {26'h0, e[i]}, {26'h0, ctrl});
            rdc("ctrl", 12'h074, {16'h0, v[i]});
        end
    endtask
    task automatic t_swap;
        apb(1'b1, 12'h074, 32'h0880);
        rx_chk(10'h27c, 10'h2bc);
        rx_chk(10'h155, 10'h155);
        tx_chk(10'h2bc, 10'h27c);
        apb(1'b1, 12'h078, 32'h8002);
        apb(1'b1, 12'h07c, 32'h155);
        rx_chk(10'h155, 10'h2bc);
        apb(1'b1, 12'h074, 32'h0080);
        rx_chk(10'h155, 10'h155);
        apb(1'b1, 12'h074, 32'h0800);
        tx_chk(10'h2bc, 10'h2bc);
    endtask
    task automatic t_sync;
        int nb;
        apb(1'b1, 12'h084, 32'h1);
        for (int p = 0; p < 4; p++) begin
            nb = (p == 0) ? 4 : p;
            apb(1'b1, 12'h074, 32'h0880 | p);
            lock();
            chk("synced", 32'h1, {31'h0, synced});
            chk("irq_masked", 32'h0, {31'h0, irq});
            if (p == 0) chk("align", 32'h3, {28'h0, align_pos});
            if (p == 0) rdc("status", 12'h088, 32'h630);
            if (p > 0) begin
                bad(nb - 1);
                link_u.send(1'b0, 1'b0, 1'b0, 4'h0, 10'h0aa);
            end
            bad(nb - 1);
            chk("synced", 32'h1, {31'h0, synced});
            bad(1);
            chk("synced", 32'h0, {31'h0, synced});
            chk("irq", 32'h1, {31'h0, irq});
            rdc("irq_stat", 12'h080, 32'h7);
            apb(1'b1, 12'h080, 32'h7);
            repeat (2) @(negedge pclk);
            chk("irq_clear", 32'h0, {31'h0, irq});
        end
    endtask
    task automatic t_align;
        apb(1'b1, 12'h074, 32'h08a0);
        repeat (2) @(negedge pclk);
        chk("align", 32'h9, {28'h0, align_pos});
        // Slip enable set alongside force: the jog position must win
        apb(1'b1, 12'h074, 32'h08b0);
        repeat (12) apb(1'b1, 12'h08c, 32'h1);
        repeat (2) @(negedge pclk);
        chk("jog_align", 32'h2, {28'h0, align_pos});
        rdc("jog", 12'h08c, 32'h2);
        apb(1'b1, 12'h074, 32'h0880);
        repeat (2) @(negedge pclk);
        chk("align", 32'h3, {28'h0, align_pos});
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        tx_in = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_ctrl();
        t_swap();
        t_sync();
        t_align();
        end_sim();
    end
endmodule // hs_channel_sync_coding_control_test
